// ===== src/iuvt_regs.sv
// input start/stop threshold registers, status flags and run decision
`include "iuvt_map.svh"
module iuvt_regs
   import iuvt_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        resetn,
   input  wire logic        ce,
   input  wire logic        cmdValid,
   input  wire logic        cmdWrite,
   input  wire logic [7:0]  cmdCode,
   input  wire logic [15:0] wrData,
   input  wire logic [6:0]  nvStartIn,
   input  wire logic [6:0]  nvStopIn,
   input  wire logic [6:0]  vinMeasure,
   input  wire logic        startOk,
   output logic [15:0]      rdData,
   output logic             rspValid,
   output logic             cmlFlag,
   output logic             ivdFlag,
   output logic             alertOe,
   output logic             convRun,
   output logic             nvStrobe,
   output logic [6:0]       nvStart,
   output logic [6:0]       nvStop
);

   //==============================================================
   // nearest-entry search
   // ties resolve to the lower voltage, which is the safer side for both thresholds
   function automatic iuvt_mant_t snap(input iuvt_mant_t v, input logic [`IUVT_SET_N*7-1:0] set);
      iuvt_mant_t best;
      iuvt_mant_t bestDiff;
      iuvt_mant_t e;
      iuvt_mant_t d;
      best = set[6:0];
      bestDiff = (v > best) ? iuvt_mant_t'(v - best) : iuvt_mant_t'(best - v);
      for (int i = 1; i < `IUVT_SET_N; i++) begin
         e = set[i*7 +: 7];
         d = (v > e) ? iuvt_mant_t'(v - e) : iuvt_mant_t'(e - v);
         if (d < bestDiff) begin
            best = e;
            bestDiff = d;
         end
      end
      return best;
   endfunction

   // membership test for the checks below, kept apart from the search so that it can catch it
   function automatic logic isMember(input iuvt_mant_t v, input logic [`IUVT_SET_N*7-1:0] set);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `IUVT_SET_N; i++) begin
         if (set[i*7 +: 7] == v) begin
            hit = 1'b1;
         end
      end
      return hit;
   endfunction

   //==============================================================
   // decode
   iuvt_state_t st;
   iuvt_state_t next_st;
   logic        wrStart;
   logic        wrStop;
   logic        wrClear;
   logic        wrStore;
   logic        wrRestore;
   logic        rdAny;
   iuvt_mant_t  wrMant;
   iuvt_mant_t  startRnd;
   iuvt_mant_t  stopRnd;
   logic        startRange;
   logic        stopRange;
   logic        startOrder;
   logic        stopOrder;
   logic        badWrite;

   assign wrStart   = cmdValid && cmdWrite && cmdCode == `IUVT_CMD_START;
   assign wrStop    = cmdValid && cmdWrite && cmdCode == `IUVT_CMD_STOP;
   assign wrClear   = cmdValid && cmdWrite && cmdCode == `IUVT_CMD_CLEAR;
   assign wrStore   = cmdValid && cmdWrite && cmdCode == `IUVT_CMD_STORE;
   assign wrRestore = cmdValid && cmdWrite && cmdCode == `IUVT_CMD_RESTORE;
   assign rdAny     = cmdValid && !cmdWrite;
   // exponent and upper mantissa bits of the written word are ignored
   assign wrMant    = wrData[6:0];
   assign startRnd  = snap(wrMant, `IUVT_START_SET);
   assign stopRnd   = snap(wrMant, `IUVT_STOP_SET);
   assign startRange = wrMant < `IUVT_START_MIN || wrMant > `IUVT_START_MAX;
   assign stopRange  = wrMant < `IUVT_STOP_MIN || wrMant > `IUVT_STOP_MAX;
   assign startOrder = startRnd <= st.stopMant;
   assign stopOrder  = stopRnd >= st.startMant;
   assign badWrite   = (wrStart && (startRange || startOrder)) || (wrStop && (stopRange || stopOrder));

   //==============================================================
   // next state
   always_comb begin
      next_st = st;
      next_st.rspValid = 1'b0;
      next_st.nvStrobe = 1'b0;
      if (wrStart && !startRange && !startOrder) begin
         next_st.startMant = startRnd;
      end
      if (wrStop && !stopRange && !stopOrder) begin
         next_st.stopMant = stopRnd;
      end
      if (wrRestore) begin
         next_st.startMant = nvStartIn;
         next_st.stopMant = nvStopIn;
      end
      if (wrStore) begin
         next_st.nvStart = st.startMant;
         next_st.nvStop = st.stopMant;
         next_st.nvStrobe = 1'b1;
      end
      // a rejected write in the same cycle as a clear still leaves the flags set
      if (wrClear) begin
         next_st.cml = 1'b0;
         next_st.ivd = 1'b0;
         next_st.alertOe = 1'b0;
      end
      if (badWrite) begin
         next_st.cml = 1'b1;
         next_st.ivd = 1'b1;
         next_st.alertOe = 1'b1;
      end
      if (rdAny) begin
         next_st.rspValid = 1'b1;
         case (cmdCode)
            `IUVT_CMD_START: next_st.rdData = {`IUVT_EXP, 4'h0, st.startMant};
            `IUVT_CMD_STOP:  next_st.rdData = {`IUVT_EXP, 4'h0, st.stopMant};
            default:         next_st.rdData = 16'h0000;
         endcase
      end
      // hysteresis: run from start level down to stop level, voltage in quarter volts
      if (!st.convRun && vinMeasure >= st.startMant && startOk) begin
         next_st.convRun = 1'b1;
      end else if (st.convRun && vinMeasure <= st.stopMant) begin
         next_st.convRun = 1'b0;
      end
   end

   //==============================================================
   // state register
   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         st <= '0;
         st.startMant <= `IUVT_START_RST;
         st.stopMant <= `IUVT_STOP_RST;
         st.nvStart <= `IUVT_START_RST;
         st.nvStop <= `IUVT_STOP_RST;
      end else if (ce) begin
         st <= next_st;
      end
   end

   assign rdData   = st.rdData;
   assign rspValid = st.rspValid;
   assign cmlFlag  = st.cml;
   assign ivdFlag  = st.ivd;
   assign alertOe  = st.alertOe;
   assign convRun  = st.convRun;
   assign nvStrobe = st.nvStrobe;
   assign nvStart  = st.nvStart;
   assign nvStop   = st.nvStop;

   //==============================================================
   // checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   a_start_reset: assert property ($rose(resetn) |-> st.startMant == `IUVT_START_RST)
      else $error("start threshold not at reset value");
   a_stop_reset: assert property ($rose(resetn) |-> st.stopMant == `IUVT_STOP_RST)
      else $error("stop threshold not at reset value");
   a_nv_reset: assert property ($rose(resetn) |->
         nvStart == `IUVT_START_RST && nvStop == `IUVT_STOP_RST)
      else $error("store data not at reset value");
   a_flags_reset: assert property ($rose(resetn) |-> !cmlFlag && !ivdFlag && !alertOe && !convRun && !rspValid)
      else $error("status not clear after reset");
   a_read_format: assert property (rspValid |-> rdData[10:7] == 4'h0 &&
         (rdData[15:11] == `IUVT_EXP || rdData == 16'h0000))
      else $error("threshold word has wrong fixed fields");
   a_range_hold: assert property (ce && wrStart && startRange && !wrRestore |=>
         st.startMant == $past(st.startMant))
      else $error("out-of-range write changed start threshold");
   a_invalid_flags: assert property (ce && badWrite |=> cmlFlag && ivdFlag)
      else $error("invalid write did not raise flags");
   a_order_reject: assert property (ce && wrStop && !stopRange && stopOrder && !wrRestore |=>
         alertOe && st.stopMant == $past(st.stopMant))
      else $error("mis-ordered stop write accepted");
   a_round_take: assert property (ce && wrStart && !startRange && !startOrder && !wrRestore |=>
         st.startMant == $past(startRnd) && st.startMant > st.stopMant)
      else $error("start threshold not rounded and stored");
   a_clear_faults: assert property (ce && wrClear && !badWrite |=> !cmlFlag && !ivdFlag && !alertOe)
      else $error("clear did not release status");
   a_run_start: assert property (ce && !convRun && vinMeasure >= st.startMant && startOk |=> convRun)
      else $error("conversion did not start");
   a_run_stop: assert property (ce && convRun && vinMeasure <= st.stopMant |=> !convRun)
      else $error("conversion did not stop");
   a_nv_save: assert property (ce && wrStore |=> nvStrobe && nvStart == $past(st.startMant)
         && nvStop == $past(st.stopMant))
      else $error("save did not copy thresholds");
   a_nv_hold: assert property (!(ce && wrStore) |=> nvStart == $past(nvStart) && nvStop == $past(nvStop))
      else $error("store data moved without a save");
   a_nv_pulse: assert property (ce && !wrStore |=> !nvStrobe)
      else $error("store strobe longer than one cycle");
   a_restore_load: assert property (ce && wrRestore |=>
         st.startMant == $past(nvStartIn) && st.stopMant == $past(nvStopIn))
      else $error("restore did not load stored thresholds");

   //==============================================================
   // write path: a stored value only moves on an accepted write or a restore
   a_stop_range_hold: assert property (ce && wrStop && stopRange |=> st.stopMant == $past(st.stopMant))
      else $error("out-of-range write changed stop threshold");
   a_start_order_reject: assert property (ce && wrStart && !startRange && startOrder |=>
         alertOe && st.startMant == $past(st.startMant))
      else $error("mis-ordered start write accepted");
   a_stop_round_take: assert property (ce && wrStop && !stopRange && !stopOrder |=>
         st.stopMant == $past(stopRnd) && st.startMant > st.stopMant)
      else $error("stop threshold not rounded and stored");
   a_start_hold: assert property (!(ce && (wrStart || wrRestore)) |=> st.startMant == $past(st.startMant))
      else $error("start threshold moved without a write");
   a_stop_hold: assert property (!(ce && (wrStop || wrRestore)) |=> st.stopMant == $past(st.stopMant))
      else $error("stop threshold moved without a write");
   // a restore may load a mis-ordered pair, so only writes are held to the order
   a_order_kept: assert property (st.startMant > st.stopMant && !(ce && wrRestore) |=>
         st.startMant > st.stopMant)
      else $error("threshold order broken by a write");
   a_start_range_flags: assert property (ce && wrStart && startRange |=> cmlFlag && ivdFlag && alertOe)
      else $error("out-of-range start write raised no flags");
   a_stop_range_flags: assert property (ce && wrStop && stopRange |=> cmlFlag && ivdFlag && alertOe)
      else $error("out-of-range stop write raised no flags");
   a_start_order_flags: assert property (ce && wrStart && !startRange && startOrder |=> cmlFlag && ivdFlag)
      else $error("mis-ordered start write raised no flags");
   a_stop_order_flags: assert property (ce && wrStop && !stopRange && stopOrder |=> cmlFlag && ivdFlag)
      else $error("mis-ordered stop write raised no flags");

   //==============================================================
   // rounding, checked against the sets rather than against the search
   // the widest gaps are four quarter volts in the start set and seven in the stop set
   a_start_near_entry: assert property (ce && wrStart && !startRange && !startOrder |=>
         (st.startMant >= $past(wrMant) ? st.startMant - $past(wrMant) : $past(wrMant) - st.startMant) <= 7'h02)
      else $error("start threshold not rounded to a near entry");
   a_stop_near_entry: assert property (ce && wrStop && !stopRange && !stopOrder |=>
         (st.stopMant >= $past(wrMant) ? st.stopMant - $past(wrMant) : $past(wrMant) - st.stopMant) <= 7'h03)
      else $error("stop threshold not rounded to a near entry");
   a_start_member: assert property (ce && wrStart && !startRange && !startOrder |=>
         isMember(st.startMant, `IUVT_START_SET))
      else $error("start threshold is not a supported entry");
   a_stop_member: assert property (ce && wrStop && !stopRange && !stopOrder |=>
         isMember(st.stopMant, `IUVT_STOP_SET))
      else $error("stop threshold is not a supported entry");

   //==============================================================
   // read word and command port
   a_read_start: assert property (ce && rdAny && cmdCode == `IUVT_CMD_START |=>
         rspValid && rdData == {`IUVT_EXP, 4'h0, $past(st.startMant)})
      else $error("start threshold read back wrong");
   a_read_stop: assert property (ce && rdAny && cmdCode == `IUVT_CMD_STOP |=>
         rspValid && rdData == {`IUVT_EXP, 4'h0, $past(st.stopMant)})
      else $error("stop threshold read back wrong");
   a_read_other: assert property (ce && rdAny && cmdCode != `IUVT_CMD_START && cmdCode != `IUVT_CMD_STOP |=>
         rspValid && rdData == 16'h0000)
      else $error("read of another code returned data");
   a_rsp_pulse: assert property (ce && !rdAny |=> !rspValid)
      else $error("response without a read");
   a_rdata_hold: assert property (!(ce && rdAny) |=> rdData == $past(rdData))
      else $error("read word moved without a read");
   a_ce_freeze: assert property (!ce |=> st == $past(st))
      else $error("state moved while clock enable low");

   //==============================================================
   // status flags stay set until a clear
   a_cml_sticky: assert property (cmlFlag && !(ce && wrClear) |=> cmlFlag)
      else $error("command-error flag dropped without a clear");
   a_ivd_sticky: assert property (ivdFlag && !(ce && wrClear) |=> ivdFlag)
      else $error("invalid-data flag dropped without a clear");
   a_alert_sticky: assert property (alertOe && !(ce && wrClear) |=> alertOe)
      else $error("alert released without a clear");
   a_no_false_flag: assert property (!cmlFlag && !ivdFlag && !(ce && badWrite) |=> !cmlFlag && !ivdFlag)
      else $error("status flag raised by a valid command");

   //==============================================================
   // run decision changes only at a crossing
   a_run_hold_on: assert property (convRun && !(ce && vinMeasure <= st.stopMant) |=> convRun)
      else $error("conversion stopped above the stop threshold");
   a_run_hold_off: assert property (!convRun && !(ce && vinMeasure >= st.startMant && startOk) |=> !convRun)
      else $error("conversion started without its conditions");
   a_run_no_ok: assert property (!convRun && !startOk |=> !convRun)
      else $error("conversion started without the other conditions");
   a_run_rise_cause: assert property ($rose(convRun) |->
         $past(vinMeasure) >= $past(st.startMant) && $past(startOk))
      else $error("conversion rose below the start threshold");
   a_run_fall_cause: assert property ($fell(convRun) |->
         $past(vinMeasure) <= $past(st.stopMant))
      else $error("conversion fell above the stop threshold");

   c_start_ok: cover property (ce && wrStart && !badWrite ##[1:9] convRun);
   c_restore_load: cover property (ce && wrRestore ##1 st.startMant <= st.stopMant);
   c_reject: cover property (ce && wrStop && stopOrder ##1 alertOe);
   c_clear: cover property (alertOe ##1 ce && wrClear ##1 !alertOe);
   c_stop_run: cover property (convRun ##1 !convRun);

endmodule

// ===== src/iuvt_map.svh
// constants of the input under-voltage threshold register bank
//==============================================================
// Behaviour
// - conversion may start when input voltage reaches start threshold and other conditions hold
// - conversion stops when input voltage falls to the stop threshold
// - written thresholds snap to the nearest entry of their supported voltage set
// - a written threshold outside its supported range is invalid data
// - invalid threshold writes set command-error and invalid-data flags
// - out-of-range writes leave the stored threshold unchanged
// - start must stay above stop; violating writes rejected, alert asserted, flags set; restore loads its pair without the order check
// - save-all-settings copies both thresholds to nonvolatile store as power-up default
// - threshold word is 5-bit exponent over 11-bit two's complement mantissa
// - only the low 7 mantissa bits are writable
// - exponent reads -2, four upper mantissa bits read zero
// - start threshold resets to mantissa 9
// - stop threshold resets to mantissa 8
// - clear-faults clears all status and releases alert; live fault re-sets at once
`ifndef IUVT_MAP_SVH
`define IUVT_MAP_SVH

//==============================================================
// command codes
`define IUVT_CMD_CLEAR    8'h03
`define IUVT_CMD_STORE    8'h15
`define IUVT_CMD_RESTORE  8'h16
`define IUVT_CMD_START    8'h35
`define IUVT_CMD_STOP     8'h36

//==============================================================
// word layout
`define IUVT_MANT_W       7
`define IUVT_EXP          5'h1e
`define IUVT_EXP_LSB      11
`define IUVT_START_RST    7'h09
`define IUVT_STOP_RST     7'h08

//==============================================================
// supported sets in quarter volts, ascending from the low end
`define IUVT_SET_N        31
`define IUVT_START_SET    {7'h40, 7'h3c, 7'h38, 7'h34, 7'h32, 7'h30, 7'h2e, 7'h2c, 7'h2a, 7'h28, \
                           7'h26, 7'h25, 7'h24, 7'h23, 7'h22, 7'h21, 7'h20, 7'h1e, 7'h1d, 7'h1c, \
                           7'h1b, 7'h1a, 7'h19, 7'h18, 7'h17, 7'h16, 7'h15, 7'h14, 7'h13, 7'h12, 7'h11}
`define IUVT_STOP_SET     {7'h3f, 7'h3f, 7'h3b, 7'h37, 7'h30, 7'h2f, 7'h2d, 7'h2b, 7'h29, 7'h27, \
                           7'h25, 7'h24, 7'h23, 7'h22, 7'h21, 7'h20, 7'h1e, 7'h1d, 7'h1c, 7'h1b, \
                           7'h1a, 7'h19, 7'h18, 7'h17, 7'h16, 7'h15, 7'h14, 7'h13, 7'h12, 7'h11, 7'h10}
`define IUVT_START_MIN    7'h11
`define IUVT_START_MAX    7'h40
`define IUVT_STOP_MIN     7'h10
`define IUVT_STOP_MAX     7'h3f

`endif

// ===== src/iuvt_pkg.sv
// types of the input under-voltage threshold register bank
`include "iuvt_map.svh"
package iuvt_pkg;

   typedef logic [`IUVT_MANT_W-1:0] iuvt_mant_t;

   typedef struct packed {
      iuvt_mant_t  startMant;
      iuvt_mant_t  stopMant;
      logic        cml;
      logic        ivd;
      logic        alertOe;
      logic [15:0] rdData;
      logic        rspValid;
      logic        convRun;
      logic        nvStrobe;
      iuvt_mant_t  nvStart;
      iuvt_mant_t  nvStop;
   } iuvt_state_t;

endpackage

// ===== dv/iuvt_host.sv
// host model that issues word commands to the threshold bank
module iuvt_host (
   input  wire logic        sys_clk,
   output logic             cmdValid = 1'b0,
   output logic             cmdWrite = 1'b0,
   output logic [7:0]       cmdCode = 8'h00,
   output logic [15:0]      wrData = 16'h0000
);
   timeunit 1ns;
   timeprecision 100ps;

   // one whole word per command; a gap lets the host answer slowly
   task automatic issue(input logic w, input logic [7:0] c, input logic [15:0] d, input int gap);
      cmdWrite = w;
      cmdCode  = c;
      wrData   = d;
      cmdValid = 1'b1;
      @(posedge sys_clk);
      #1;
      if (gap > 0) begin
         cmdValid = 1'b0;
         // a released bus shows no stale word
         cmdCode = ~c;
         wrData  = ~d;
         repeat (gap) @(posedge sys_clk);
         #1;
      end
   endtask
endmodule

// ===== dv/iuvt_regs_bench.sv
// self-checking bench of the input threshold bank against a behavioural model
module iuvt_regs_bench;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct {int start, stop, run, rsp, rd, flag, nv, nvS, nvP;} iuvt_model_t;
   logic        sys_clk = 1'b0, resetn = 1'b0, ce = 1'b1, startOk = 1'b0;
   logic [6:0]  nvStartIn = 7'h00, nvStopIn = 7'h00, vinMeasure = 7'h00, nvStart, nvStop;
   logic        cmdValid, cmdWrite, rspValid, cmlFlag, ivdFlag, alertOe, convRun, nvStrobe;
   logic [7:0]  cmdCode;
   logic [15:0] wrData, rdData;
   logic [7:0]  codes[6] = '{8'h03, 8'h15, 8'h16, 8'h35, 8'h36, 8'h20};
   logic [15:0] edgeData[10] = '{16'h0010, 16'hff40, 16'h0041, 16'h000f, 16'h0040, 16'h003f, 16'h003e, 16'h0010,
                                 16'h003e, 16'h003e};
   logic [7:0]  edgeCode[10] = '{8'h35, 8'h35, 8'h35, 8'h36, 8'h36, 8'h36, 8'h35, 8'h36, 8'h35, 8'h36};
   int          err_count = 0, tests_run = 0, cycles = 0, d;
   iuvt_model_t mdl;

   iuvt_host u_iuvt_host (.sys_clk(sys_clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode),
                          .wrData(wrData));
   iuvt_regs u_iuvt_regs (.sys_clk(sys_clk), .resetn(resetn), .ce(ce), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
                          .cmdCode(cmdCode), .wrData(wrData), .nvStartIn(nvStartIn), .nvStopIn(nvStopIn),
                          .vinMeasure(vinMeasure), .startOk(startOk), .rdData(rdData), .rspValid(rspValid),
                          .cmlFlag(cmlFlag), .ivdFlag(ivdFlag), .alertOe(alertOe), .convRun(convRun),
                          .nvStrobe(nvStrobe), .nvStart(nvStart), .nvStop(nvStop));

   //==============================================================
   // supported sets in quarter volts
   function automatic bit inSet(int e, bit st);
      if (st) return (e >= 17 && e <= 38 && e != 31) || (e >= 40 && e <= 52 && e % 2 == 0) || e inside {56, 60, 64};
      return (e >= 16 && e <= 37 && e != 31) || (e >= 39 && e <= 47 && e % 2 == 1) || e inside {48, 55, 59, 63};
   endfunction

   // ascending search with strict compare, so ties land on the lower entry
   function automatic int near(int v, bit st);
      int best = 0;
      int bd = 999;
      for (int e = 16; e <= 64; e++)
         if (inSet(e, st) && (v > e ? v - e : e - v) < bd) begin
            best = e;
            bd = v > e ? v - e : e - v;
         end
      return best;
   endfunction

   //==============================================================
   // model
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn)
         mdl = '{9, 8, 0, 0, 0, 0, 0, 9, 8};
      else if (ce === 1'b1) begin
         mdl.rsp = 0;
         mdl.nv = 0;
         if (mdl.run == 0 && vinMeasure >= mdl.start && startOk) mdl.run = 1;
         else if (mdl.run == 1 && vinMeasure <= mdl.stop) mdl.run = 0;
         d = wrData[6:0];
         if (cmdValid && !cmdWrite) begin
            mdl.rsp = 1;
            mdl.rd = cmdCode == 8'h35 ? mdl.start : cmdCode == 8'h36 ? mdl.stop : -1;
         end else if (cmdValid) begin
            case (cmdCode)
               8'h03: mdl.flag = 0;
               8'h15: mdl = '{mdl.start, mdl.stop, mdl.run, 0, mdl.rd, mdl.flag, 1, mdl.start, mdl.stop};
               8'h16: mdl = '{nvStartIn, nvStopIn, mdl.run, 0, mdl.rd, mdl.flag, 0, mdl.nvS, mdl.nvP};
               8'h35: if (d < 17 || d > 64 || near(d, 1) <= mdl.stop) mdl.flag = 1;
                      else mdl.start = near(d, 1);
               8'h36: if (d < 16 || d > 63 || near(d, 0) >= mdl.start) mdl.flag = 1;
                      else mdl.stop = near(d, 0);
               default: ;
            endcase
         end
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
      tests_run++;
      if (got !== exp) begin
         err_count++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   always @(negedge sys_clk) begin
      cycles++;
      if (cycles > 20000) begin
         err_count++;
         $display("[ERR] %0t run timed out", $time);
         test_done();
      end else if (resetn === 1'b1) begin
         check({rspValid, cmlFlag, ivdFlag, alertOe, convRun, nvStrobe, nvStart, nvStop}, {mdl.rsp[0], {3{mdl.flag[0]}}, mdl.run[0], mdl.nv[0], 7'(mdl.nvS), 7'(mdl.nvP)}, "status");
         if (mdl.rsp == 1) check(rdData, mdl.rd < 0 ? 16'h0000 : {5'b11110, 4'b0000, 7'(mdl.rd)}, "read word");
      end
   end

   //==============================================================
   // stimulus
   initial begin
      forever #2.5 sys_clk = ~sys_clk;
   end

   initial begin
      void'($urandom(95));
      repeat (3) @(posedge sys_clk);
      #1;
      resetn = 1'b1;
      foreach (codes[i]) u_iuvt_host.issue(1'b0, codes[i], 16'h0000, 0);
      $display("test reset reads done");
      // range edges, tie rounding, order violation both ways, then clear and save
      foreach (edgeData[i]) begin
         u_iuvt_host.issue(1'b1, edgeCode[i], edgeData[i], 0);
         u_iuvt_host.issue(1'b0, edgeCode[i], 16'h0000, 1);
      end
      u_iuvt_host.issue(1'b1, 8'h03, 16'h0000, 0);
      u_iuvt_host.issue(1'b1, 8'h15, 16'h0000, 1);
      $display("test edges done");
      repeat (1500) begin
         vinMeasure = 7'($urandom % 70);
         startOk = ($urandom % 4) != 0;
         ce = ($urandom % 8) != 0;
         nvStartIn = 7'($urandom);
         nvStopIn = 7'($urandom);
         u_iuvt_host.issue(($urandom % 4) != 0, codes[$urandom % 6], 16'($urandom), $urandom % 3);
      end
      u_iuvt_host.issue(1'b0, 8'h35, 16'h0000, 2);
      $display("test random traffic done");
      test_done();
   end
endmodule
